// file: src/scr_regs.v
// Configuration and raw result register bank with host interface selection
`timescale 1ns/1ps
`include "scr_consts.vh"
module scr_regs (
    input wire mclk_i,
    input wire reset_n_i,
    input wire chip_sel_n_i,
    input wire [1:0] op_mode_i,
    input wire wr_en_i,
    input wire rd_en_i,
    input wire [7:0] addr_i,
    input wire [7:0] wr_data_i,
    input wire [2:0] press_res_i,
    input wire conv_busy_i,
    input wire result_load_i,
    input wire [19:0] raw_press_word_i,
    input wire [19:0] raw_thermal_word_i,
    input wire [15:0] raw_moisture_word_i,
    output reg [7:0] rd_data_o,
    output reg [2:0] standby_time_sel_o,
    output reg [2:0] smoothing_sel_o,
    output reg three_wire_serial_on_o,
    output reg [4:0] flt_coef_o,
    output reg [13:0] standby_tenth_ms_o,
    output reg standby_active_o,
    output reg two_wire_on_o,
    output reg serial_port_on_o,
    output reg measuring_o
);
    // Stored registers
    reg [7:0] cfg_q;
    reg [19:0] press_q;
    reg [19:0] therm_q;
    reg [15:0] moist_q;
    reg spi_lock_q;
    reg [7:0] rd_d;

    // Address hits
    wire hit_cfg;
    wire hit_p_hi;
    wire hit_p_mid;
    wire hit_p_lo;
    wire hit_t_hi;
    wire hit_t_mid;
    wire hit_t_lo;
    wire hit_h_hi;
    wire hit_h_lo;

    // Byte images of the stored registers
    wire [7:0] cfg_byte;
    wire [7:0] p_hi_byte;
    wire [7:0] p_mid_byte;
    wire [7:0] p_lo_byte;
    wire [7:0] t_hi_byte;
    wire [7:0] t_mid_byte;
    wire [7:0] t_lo_byte;
    wire [7:0] h_hi_byte;
    wire [7:0] h_lo_byte;

    // Control and decode
    wire is_normal;
    wire cfg_hit;
    wire cfg_wr_ok;
    wire [3:0] nib_mask;
    wire [3:0] press_nib;
    wire [2:0] sb_code;
    wire [2:0] flt_code;
    wire [13:0] sb_time;
    wire [4:0] coef;
    genvar g;

    // Next values of the status outputs
    wire lock_next;
    wire two_wire_next;
    wire serial_next;
    wire meas_next;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode shared by the write and read paths
    assign hit_cfg = (addr_i == `SCR_ADDR_CFG);
    assign hit_p_hi = (addr_i == `SCR_ADDR_P_HI);
    assign hit_p_mid = (addr_i == `SCR_ADDR_P_MID);
    assign hit_p_lo = (addr_i == `SCR_ADDR_P_LO);
    assign hit_t_hi = (addr_i == `SCR_ADDR_T_HI);
    assign hit_t_mid = (addr_i == `SCR_ADDR_T_MID);
    assign hit_t_lo = (addr_i == `SCR_ADDR_T_LO);
    assign hit_h_hi = (addr_i == `SCR_ADDR_H_HI);
    assign hit_h_lo = (addr_i == `SCR_ADDR_H_LO);

    ////////////////////////////////////////////////////////////////////////////
    // Operating mode
    assign is_normal = (op_mode_i == `SCR_MODE_NORMAL); // R16

    ////////////////////////////////////////////////////////////////////////////
    // Register writes; result addresses have no write path
    assign cfg_hit = wr_en_i && hit_cfg; // R11
    // Normal mode drops configuration writes; sleep and forced keep them
    assign cfg_wr_ok = cfg_hit && !is_normal; // R1

    // Bit 1 is masked off on the way in so it always reads zero
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cfg_q <= `SCR_CFG_RESET;
        end else if (cfg_wr_ok) begin
            cfg_q <= wr_data_i & `SCR_CFG_MASK; // R18
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Result capture; all three words load together, but a burst read that spans a load can mix conversions
    // Reset values are the skipped-conversion markers
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            press_q <= `SCR_P_RESET;
        end else if (result_load_i) begin
            press_q <= raw_press_word_i; // R5
        end
    end

    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            therm_q <= `SCR_T_RESET;
        end else if (result_load_i) begin
            therm_q <= raw_thermal_word_i; // R6
        end
    end

    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            moist_q <= `SCR_H_RESET;
        end else if (result_load_i) begin
            moist_q <= raw_moisture_word_i; // R7
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Resolution mask: each step above the first, up to 5, keeps one more low pressure bit
    generate
        for (g = 0; g < `SCR_NIB_W; g = g + 1) begin : g_nib
            assign nib_mask[`SCR_NIB_W - 1 - g] = (press_res_i >= `SCR_RES_FIRST + g); // R8
        end
    endgenerate
    assign press_nib = press_q[3:0] & nib_mask; // R8

    ////////////////////////////////////////////////////////////////////////////
    // Byte images; low nibbles sit in bits 7..4 with zeros below
    assign cfg_byte = cfg_q;
    assign p_hi_byte = press_q[19:12]; // R5
    assign p_mid_byte = press_q[11:4]; // R5
    assign p_lo_byte = {press_nib, 4'h0}; // R5 R8
    assign t_hi_byte = therm_q[19:12]; // R6
    assign t_mid_byte = therm_q[11:4]; // R6
    assign t_lo_byte = {therm_q[3:0], 4'h0}; // R6
    assign h_hi_byte = moist_q[15:8]; // R7
    assign h_lo_byte = moist_q[7:0]; // R7

    ////////////////////////////////////////////////////////////////////////////
    // Read decode; unmapped addresses read as zero
    always @* begin
        rd_d = 8'h00;
        if (hit_cfg) begin
            rd_d = cfg_byte;
        end else if (hit_p_hi) begin
            rd_d = p_hi_byte;
        end else if (hit_p_mid) begin
            rd_d = p_mid_byte;
        end else if (hit_p_lo) begin
            rd_d = p_lo_byte;
        end else if (hit_t_hi) begin
            rd_d = t_hi_byte;
        end else if (hit_t_mid) begin
            rd_d = t_mid_byte;
        end else if (hit_t_lo) begin
            rd_d = t_lo_byte;
        end else if (hit_h_hi) begin
            rd_d = h_hi_byte;
        end else if (hit_h_lo) begin
            rd_d = h_lo_byte;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Standby and smoothing decode
    assign sb_code = cfg_q[`SCR_SB_MSB:`SCR_SB_LSB]; // R2
    assign flt_code = cfg_q[`SCR_FLT_MSB:`SCR_FLT_LSB]; // R3

    // Table lookups live in their own module
    scr_filter_decode u_dec (
        .sb_code_i(sb_code),
        .flt_code_i(flt_code),
        .standby_tenth_ms_o(sb_time),
        .flt_coef_o(coef)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Interface lock: one low chip-select level keeps the serial port until reset
    assign lock_next = spi_lock_q || !chip_sel_n_i; // R14
    assign two_wire_next = chip_sel_n_i && !spi_lock_q; // R13 R14
    assign serial_next = !chip_sel_n_i || spi_lock_q; // R9 R13

    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            spi_lock_q <= 1'b0;
        end else begin
            spi_lock_q <= lock_next; // R14
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered configuration fields
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            standby_time_sel_o <= 3'h0;
        end else begin
            standby_time_sel_o <= sb_code; // R2
        end
    end

    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            smoothing_sel_o <= 3'h0;
        end else begin
            smoothing_sel_o <= flt_code; // R3
        end
    end

    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            three_wire_serial_on_o <= 1'b0;
        end else begin
            three_wire_serial_on_o <= cfg_q[`SCR_3W_BIT]; // R4
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered decoded values
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            flt_coef_o <= 5'h00;
        end else begin
            flt_coef_o <= coef; // R3
        end
    end

    // Tenths of a millisecond; the longest code needs all 14 bits
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            standby_tenth_ms_o <= 14'h0000;
        end else begin
            standby_tenth_ms_o <= sb_time; // R2
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode and conversion flags
    // The busy flag drops in the load cycle itself, so it never lags the new result
    assign meas_next = conv_busy_i && !result_load_i; // R17

    // Standby timing applies only in normal mode
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            standby_active_o <= 1'b0;
        end else begin
            standby_active_o <= is_normal; // R16
        end
    end

    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            measuring_o <= 1'b0;
        end else begin
            measuring_o <= meas_next; // R17
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Selected host interface; neither port is on while reset is held
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            two_wire_on_o <= 1'b0;
        end else begin
            two_wire_on_o <= two_wire_next; // R13 R14
        end
    end

    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            serial_port_on_o <= 1'b0;
        end else begin
            serial_port_on_o <= serial_next; // R9 R13
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data answers in the next cycle, fast enough for every link rate
    // It holds between strobes so a slow host can take it late
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_data_o <= 8'h00;
        end else if (rd_en_i) begin
            rd_data_o <= rd_d; // R10 R12
        end
    end
endmodule

// file: src/scr_consts.vh
// Constants for the sensor configuration and raw result register bank
// Functional notes
// [R1] In normal mode configuration writes may be dropped; in sleep they always land.
// [R2] Standby field bits 7..5 select idle time between normal-mode cycles.
// [R3] Smoothing field bits 4..2: 000 off, then 2, 4, 8, 16 for 100 up.
// [R4] Configuration bit 0 set selects three-wire serial port, clear selects four-wire.
// [R5] Raw pressure 20 bits over 0xF7, 0xF8 and upper nibble of 0xF9.
// [R6] Raw temperature 20 bits over 0xFA, 0xFB and upper nibble of 0xFC.
// [R7] Raw humidity 16 bits: high byte 0xFD, low byte 0xFE.
// [R8] Valid low pressure nibble bits depend on the conversion's resolution setting.
// [R9] Device is slave only; serial modes 00 and 11, three or four wire.
// [R10] Two-wire slave works at standard, fast and high speed.
// [R11] Multi-byte write is address/data pairs; each byte stored at its address.
// [R12] Multi-byte read starts at one address, advancing one per byte.
// [R13] Chip select high selects two-wire port; low selects serial port.
// [R14] One low chip-select level disables the two-wire port until power-on reset.
// [R15] Host must hold chip select high during power-on reset to use two-wire.
// [R16] Mode 00 sleep, 01/10 forced, 11 normal; standby applies in normal.
// [R17] Measuring flag is 1 while converting, 0 after results are transferred.
// [R18] Configuration bit 1 unused: reads zero, writes ignored.
`ifndef SCR_CONSTS_VH
`define SCR_CONSTS_VH
`define SCR_ADDR_CFG 8'hF5
`define SCR_ADDR_P_HI 8'hF7
`define SCR_ADDR_P_MID 8'hF8
`define SCR_ADDR_P_LO 8'hF9
`define SCR_ADDR_T_HI 8'hFA
`define SCR_ADDR_T_MID 8'hFB
`define SCR_ADDR_T_LO 8'hFC
`define SCR_ADDR_H_HI 8'hFD
`define SCR_ADDR_H_LO 8'hFE
`define SCR_CFG_RESET 8'h00
`define SCR_CFG_MASK 8'hFD
`define SCR_P_RESET 20'h80000
`define SCR_T_RESET 20'h80000
`define SCR_H_RESET 16'h8000
`define SCR_MODE_SLEEP 2'h0
`define SCR_MODE_NORMAL 2'h3
`define SCR_SB_MSB 7
`define SCR_SB_LSB 5
`define SCR_FLT_MSB 4
`define SCR_FLT_LSB 2
`define SCR_3W_BIT 0
`define SCR_NIB_W 4
`define SCR_RES_FIRST 3'h2
`define SCR_SB_0P5_MS 14'h0005
`define SCR_SB_62P5_MS 14'h0271
`define SCR_SB_125_MS 14'h04E2
`define SCR_SB_250_MS 14'h09C4
`define SCR_SB_500_MS 14'h1388
`define SCR_SB_1000_MS 14'h2710
`define SCR_SB_10_MS 14'h0064
`define SCR_SB_20_MS 14'h00C8
`endif

// file: src/scr_filter_decode.v
// Decoder of standby time code and smoothing coefficient code
`timescale 1ns/1ps
`include "scr_consts.vh"
module scr_filter_decode (
    input wire [2:0] sb_code_i,
    input wire [2:0] flt_code_i,
    output reg [13:0] standby_tenth_ms_o,
    output reg [4:0] flt_coef_o
);
    // Standby time in tenths of a millisecond
    always @* begin
        case (sb_code_i) // R2
            3'h0: standby_tenth_ms_o = `SCR_SB_0P5_MS;
            3'h1: standby_tenth_ms_o = `SCR_SB_62P5_MS;
            3'h2: standby_tenth_ms_o = `SCR_SB_125_MS;
            3'h3: standby_tenth_ms_o = `SCR_SB_250_MS;
            3'h4: standby_tenth_ms_o = `SCR_SB_500_MS;
            3'h5: standby_tenth_ms_o = `SCR_SB_1000_MS;
            3'h6: standby_tenth_ms_o = `SCR_SB_10_MS;
            default: standby_tenth_ms_o = `SCR_SB_20_MS;
        endcase
    end

    always @* begin
        case (flt_code_i) // R3
            3'h0: flt_coef_o = 5'h00;
            3'h1: flt_coef_o = 5'h02;
            3'h2: flt_coef_o = 5'h04;
            3'h3: flt_coef_o = 5'h08;
            default: flt_coef_o = 5'h10;
        endcase
    end
endmodule

// file: testbench/scr_assertions.sv
// Checker for the configuration and result register bank
`timescale 1ns/1ps
module scr_assertions (
    input wire mclk_i, input wire reset_n_i, input wire chip_sel_n_i,
    input wire [1:0] op_mode_i, input wire wr_en_i, input wire [7:0] addr_i,
    input wire [7:0] wr_data_i, input wire conv_busy_i, input wire result_load_i,
    input wire [2:0] standby_time_sel_o, input wire three_wire_serial_on_o,
    input wire standby_active_o, input wire two_wire_on_o, input wire serial_port_on_o,
    input wire measuring_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    wire cfg_wr = wr_en_i && addr_i == 8'hF5;
    a_meas_set: assert property (conv_busy_i && !result_load_i |=> measuring_o)
        else $error("busy flag not set");
    a_meas_clear: assert property (result_load_i |=> !measuring_o)
        else $error("busy flag not cleared");
    a_lock_set: assert property (!chip_sel_n_i |=> serial_port_on_o && !two_wire_on_o)
        else $error("select low did not lock");
    a_lock_hold: assert property (serial_port_on_o |=> serial_port_on_o)
        else $error("lock released");
    a_port_excl: assert property (!(serial_port_on_o && two_wire_on_o))
        else $error("both ports on");
    a_cfg_refused: assert property (cfg_wr && op_mode_i == 2'h3 ##1 !wr_en_i
        |=> $stable(standby_time_sel_o)) else $error("normal write landed");
    a_sleep_write: assert property (cfg_wr && op_mode_i == 2'h0
        |-> ##2 three_wire_serial_on_o == $past(wr_data_i[0], 2)) else $error("write lost");
    a_norm_flag: assert property ((op_mode_i == 2'h3)[*2] |-> standby_active_o)
        else $error("normal flag low");
endmodule
bind scr_regs scr_assertions i_chk (.*);

// file: testbench/scr_host.sv
// Host model issuing register writes and reads
`timescale 1ns/1ps
module scr_host (
    input wire mclk_i,
    output logic wr_en_o,
    output logic rd_en_o,
    output logic [7:0] addr_o,
    output logic [7:0] data_o
);
    integer k;
    initial {wr_en_o, rd_en_o, addr_o, data_o} = 18'h0;
    // Released lines show inverted values
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk_i);
        {wr_en_o, addr_o, data_o} = {1'b1, a, d};
        @(negedge mclk_i);
        {wr_en_o, addr_o, data_o} = {1'b0, ~a, ~d};
    endtask
    task rd(input logic [7:0] a, input integer n);
        for (k = 0; k < n; k++) begin
            @(negedge mclk_i);
            {rd_en_o, addr_o} = {1'b1, a + k[7:0]};
        end
        @(negedge mclk_i);
        {rd_en_o, addr_o} = {1'b0, ~addr_o};
    endtask
endmodule

// file: testbench/testbench.sv
// Self-checking bench for the configuration and result register bank
`timescale 1ns/1ps
module testbench;
    logic mclk_i, reset_n_i, chip_sel_n_i, wr_en_i, rd_en_i, conv_busy_i, result_load_i, pend;
    logic three_wire_serial_on_o, standby_active_o, two_wire_on_o, serial_port_on_o, measuring_o;
    logic [1:0] op_mode_i;
    logic [2:0] press_res_i, standby_time_sel_o, smoothing_sel_o;
    logic [7:0] addr_i, wr_data_i, rd_data_o, cfg, w;
    logic [19:0] raw_press_word_i, raw_thermal_word_i, p, t;
    logic [15:0] raw_moisture_word_i, h;
    logic [4:0] flt_coef_o;
    logic [13:0] standby_tenth_ms_o;
    logic [13:0] sbt [0:7] = '{14'h0005, 14'h0271, 14'h04E2, 14'h09C4, 14'h1388, 14'h2710,
        14'h0064, 14'h00C8};
    logic [7:0] exp_q [$];
    integer n_errors = 0, n_checks = 0, seed = 40, i, k;
    scr_host i_host (.mclk_i, .wr_en_o(wr_en_i), .rd_en_o(rd_en_i), .addr_o(addr_i),
        .data_o(wr_data_i));
    scr_regs i_dut (.*);
    initial begin
        mclk_i = 1'b0;
        forever #12.5 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) pend <= rd_en_i;
    always @(negedge mclk_i) if (pend === 1'b1) chk(rd_data_o, exp_q.pop_front());
    task chk(input logic [19:0] s, input logic [19:0] e);
        n_checks++;
        if (s !== e) begin
            n_errors++;
            $display("[FAIL] %0t seen %h exp %h", $time, s, e);
        end
    endtask
    function logic [7:0] ev(input logic [7:0] a);
        logic [3:0] m;
        logic [79:0] v;
        m = press_res_i < 3'h2 ? 4'h0 : press_res_i > 3'h4 ? 4'hF : 4'hF ^ (4'hF >> (press_res_i - 3'h1));
        v = {cfg, 8'h00, p[19:4], p[3:0] & m, 4'h0, t[19:4], t[3:0], 4'h0, h};
        return v[79 - 8 * (a - 8'hF5) -: 8];
    endfunction
    task rb(input logic [7:0] a, input integer n);
        for (k = 0; k < n; k++) exp_q.push_back(ev(a + k[7:0]));
        i_host.rd(a, n);
    endtask
    task tally_and_finish;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        {reset_n_i, op_mode_i, conv_busy_i, result_load_i} = 5'h0;
        chip_sel_n_i = 1'b1;
        press_res_i = 3'h5;
        {raw_press_word_i, raw_thermal_word_i, raw_moisture_word_i} = 56'h0;
        {p, t, h, cfg} = {20'h80000, 20'h80000, 16'h8000, 8'h00};
        repeat (8) @(posedge mclk_i);
        @(negedge mclk_i) reset_n_i = 1'b1;
        rb(8'hF5, 10);
        chk(two_wire_on_o, 1'b1);
        $display("reset test done");
        for (i = 0; i < 8; i++) begin
            w = {i[2:0], i[2:0], 1'b1, i[0]};
            i_host.wr(8'hF5, w);
            cfg = w & 8'hFD;
            repeat (3) @(negedge mclk_i);
            chk(flt_coef_o, 20'(i == 0 ? 0 : i > 3 ? 16 : 1 << i));
            chk(standby_tenth_ms_o, sbt[i]);
            chk(standby_time_sel_o, i[2:0]);
            chk(smoothing_sel_o, i[2:0]);
            chk(three_wire_serial_on_o, i[0]);
            rb(8'hF5, 1);
        end
        op_mode_i = 2'h3;
        i_host.wr(8'hF5, 8'h00);
        repeat (2) @(negedge mclk_i);
        chk(standby_active_o, 1'b1);
        rb(8'hF5, 1);
        op_mode_i = 2'h1;
        i_host.wr(8'hF5, 8'h24);
        {op_mode_i, cfg} = {2'h2, 8'h24};
        repeat (2) @(negedge mclk_i);
        chk(standby_active_o, 1'b0);
        rb(8'hF5, 1);
        $display("config test done");
        {op_mode_i, conv_busy_i} = 3'h1;
        repeat (2) @(negedge mclk_i);
        chk(measuring_o, 1'b1);
        {raw_press_word_i, raw_thermal_word_i, raw_moisture_word_i} =
            56'({$random(seed), $random(seed)});
        result_load_i = 1'b1;
        {p, t, h} = {raw_press_word_i, raw_thermal_word_i, raw_moisture_word_i};
        @(negedge mclk_i) {result_load_i, conv_busy_i} = 2'h0;
        @(negedge mclk_i);
        chk(measuring_o, 1'b0);
        i_host.wr(8'hF7, 8'h00);
        rb(8'hF7, 8);
        for (i = 0; i < 7; i++) begin
            press_res_i = i[2:0];
            rb(8'hF9, 1);
        end
        $display("result test done");
        chip_sel_n_i = 1'b0;
        @(negedge mclk_i) chip_sel_n_i = 1'b1;
        @(negedge mclk_i);
        chk(serial_port_on_o, 1'b1);
        chk(two_wire_on_o, 1'b0);
        $display("select test done");
        tally_and_finish;
    end
    initial begin
        repeat (5000) @(posedge mclk_i);
        n_errors++;
        tally_and_finish;
    end
endmodule
